// [hw/sram_consts.svh]
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH

`define SRAM_ADDR_W 16
`define SRAM_WORDS 65536
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_DATA_W 36
`define SRAM_PARITY_LSB 32
`define SRAM_UPPER_LSB 2
`define SRAM_LANE_ALL 4'hF
`define SRAM_LANE_NONE 4'h0
`define SRAM_QUEUE_DEPTH 16
`define SRAM_QUEUE_W 56
`define SRAM_QUEUE_MASK_LSB 0
`define SRAM_QUEUE_DATA_LSB 4
`define SRAM_QUEUE_ADDR_LSB 40

`endif

// [hw/sram_pkg.sv]
package sram_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BURST,
        ST_SNOOZE
    } port_state_type;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_READ,
        OP_WRITE
    } op_type;

endpackage

// [hw/burst_ctrl_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface burst_ctrl_if;
    logic load;
    logic step;
    logic linear;
    logic [1:0] first_low;
    logic [1:0] use_low;

    modport user (output load, output step, output linear, output first_low, input use_low);
    modport counter (input load, input step, input linear, input first_low, output use_low);
endinterface

`default_nettype wire

// [hw/burst_counter.sv]
`timescale 1ns/1ns
`default_nettype none

module burst_counter (
    input wire logic sys_clk,
    input wire logic sys_rst,
    burst_ctrl_if.counter bus
);
    logic [1:0] first;
    logic [1:0] count;
    logic [1:0] first_eff;
    logic [1:0] count_eff;

    // The address of the current cycle already includes this cycle's load or step
    always_comb begin
        first_eff = bus.load ? bus.first_low : first;
        if (bus.load) begin
            count_eff = 2'h0;
        end else if (bus.step) begin
            count_eff = count + 2'h1;
        end else begin
            count_eff = count;
        end
    end

    assign bus.use_low = bus.linear ? 2'(first_eff + count_eff) : (first_eff ^ count_eff);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            first <= 2'h0;
            count <= 2'h0;
        end else begin
            first <= first_eff;
            count <= count_eff;
        end
    end

    linear_second_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        bus.load && bus.linear ##1 bus.step && !bus.load && bus.linear
        |-> bus.use_low == 2'($past(bus.first_low) + 2'h1))
    else $error("linear burst did not increment");

    interleave_second_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        bus.load && !bus.linear ##1 bus.step && !bus.load && !bus.linear
        |-> bus.use_low == ($past(bus.first_low) ^ 2'h1))
    else $error("interleaved burst did not flip bit zero");

endmodule // burst_counter

`default_nettype wire

// [hw/sync_fifo.sv]
`timescale 1ns/1ns
`default_nettype none

module sync_fifo #(
    parameter int WIDTH = 56,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] slots [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;
    logic push;
    logic pop;

    assign in_ready = fill != FULL;
    assign out_valid = fill != '0;
    assign out_data = slots[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            slots[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            wr_ptr <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
            fill <= (PW+1)'(fill + push - pop);
        end
    end

    fifo_no_overflow_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        fill == FULL && !pop |=> fill == FULL)
    else $error("queue lost its full count");

endmodule // sync_fifo

`default_nettype wire

// [hw/sram_burst_port.sv]
`include "sram_consts.svh"
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Every synchronous pin is captured in a register on the rising clock edge.
// - A two-bit burst counter produces the addresses after the loaded first one.
// - Either address strobe starts a burst; advance input steps later addresses.
// - Burst order input picks interleaved or linear sequencing.
// - Data pins drive only while the asynchronous output enable is low.
// - Writes cover any subset of the byte lanes.
// - Each lane enable gates its own data lane and its parity bit.
// - Global write low writes all lanes, ignoring the gate and lane enables.
// - With global write high, lanes write only when the byte write gate is low.
// - Parity lanes exist on the 18 and 36 bit organisations only.
// - Deselect after a read floats the outputs after the next clock edge.
// - Address and write control are registered; the array write is self-timed.
// - Primary chip enable gates the processor strobe, sampled only on address load.
// - Second and third enables must both be active; sampled only on address load.
// - Advance low steps the burst counter; high holds the address as a wait state.
// - Processor strobe aborts any burst, loads address, reads; lane enables ignored.
// - Processor strobe ignored if primary enable high; else deselect powers down.
// - Order input low is linear, high is interleaved; it must stay static.
// - Interleaved order XORs the two low bits with 0, 1, 2, 3.
// - Linear order adds 0 to 3 to the two low bits modulo four.
// - Controller strobe aborts, loads; reads or writes if enabled, else powers down.
module sram_burst_port (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [`SRAM_ADDR_W-1:0] ext_address,
    input wire logic chip_enable_n,
    input wire logic second_chip_enable_n,
    input wire logic third_chip_enable,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic byte_write_gate_n,
    input wire logic global_write_n,
    input wire logic [`SRAM_LANES-1:0] lane_write_enable_n,
    input wire logic [`SRAM_DATA_W-1:0] data_in,
    input wire logic output_enable_n,
    input wire logic snooze_request,
    input wire logic burst_order,
    output logic [`SRAM_DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic write_queue_ready
);
    import sram_pkg::*;

    logic [`SRAM_ADDR_W-1:0] cap_addr;
    logic cap_ce_n;
    logic cap_ce2_n;
    logic cap_ce3;
    logic cap_proc_n;
    logic cap_ctrl_n;
    logic cap_adv_n;
    logic cap_bwe_n;
    logic cap_gw_n;
    logic [`SRAM_LANES-1:0] cap_lane_n;
    logic [`SRAM_DATA_W-1:0] cap_data;

    logic snooze_meta;
    logic snooze_sync;
    logic order_meta;
    logic order_sync;

    port_state_type state;
    port_state_type next_state;
    op_type op;

    logic proc_go;
    logic ctrl_go;
    logic addr_load;
    logic chip_sel;
    logic [`SRAM_LANES-1:0] wr_mask;
    logic [`SRAM_ADDR_W-1:`SRAM_UPPER_LSB] base_upper;
    logic [`SRAM_ADDR_W-1:0] cur_addr;

    logic [`SRAM_DATA_W-1:0] mem [`SRAM_WORDS];
    logic [`SRAM_DATA_W-1:0] read_word;
    logic out_valid;

    logic queue_in_valid;
    logic [`SRAM_QUEUE_W-1:0] queue_in_data;
    logic queue_out_valid;
    logic queue_out_ready;
    logic [`SRAM_QUEUE_W-1:0] queue_out_data;
    logic drain;
    logic [`SRAM_ADDR_W-1:0] drain_addr;
    logic [`SRAM_DATA_W-1:0] drain_data;
    logic [`SRAM_LANES-1:0] drain_mask;
    logic queue_in_ready_w;
    logic [`SRAM_DATA_W-1:0] merged_word;
    logic fwd;

    burst_ctrl_if bus ();

    // Strobes and enables reset to their idle levels so nothing starts out of reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cap_addr <= '0;
            cap_ce_n <= 1'b1;
            cap_ce2_n <= 1'b1;
            cap_ce3 <= 1'b0;
            cap_proc_n <= 1'b1;
            cap_ctrl_n <= 1'b1;
            cap_adv_n <= 1'b1;
            cap_bwe_n <= 1'b1;
            cap_gw_n <= 1'b1;
            cap_lane_n <= `SRAM_LANE_ALL;
            cap_data <= '0;
        end else begin
            cap_addr <= ext_address;
            cap_ce_n <= chip_enable_n;
            cap_ce2_n <= second_chip_enable_n;
            cap_ce3 <= third_chip_enable;
            cap_proc_n <= proc_addr_strobe_n;
            cap_ctrl_n <= ctrl_addr_strobe_n;
            cap_adv_n <= burst_advance_n;
            cap_bwe_n <= byte_write_gate_n;
            cap_gw_n <= global_write_n;
            cap_lane_n <= lane_write_enable_n;
            cap_data <= data_in;
        end
    end

    // Snooze and burst order are asynchronous levels, so they are synchronised
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            snooze_meta <= 1'b0;
            snooze_sync <= 1'b0;
            order_meta <= 1'b1;
            order_sync <= 1'b1;
        end else begin
            snooze_meta <= snooze_request;
            snooze_sync <= snooze_meta;
            order_meta <= burst_order;
            order_sync <= order_meta;
        end
    end

    // Processor strobe wins over the controller strobe when both are taken
    assign proc_go = !cap_proc_n && !cap_ce_n && !snooze_sync;
    assign ctrl_go = !cap_ctrl_n && !proc_go && !snooze_sync;
    assign addr_load = proc_go || ctrl_go;
    assign chip_sel = !cap_ce2_n && cap_ce3;

    assign wr_mask = !cap_gw_n ? `SRAM_LANE_ALL
                   : (!cap_bwe_n ? ~cap_lane_n : `SRAM_LANE_NONE);

    always_comb begin
        next_state = state;
        op = OP_NONE;
        if (snooze_sync) begin
            next_state = ST_SNOOZE;
        end else if (proc_go) begin
            if (chip_sel) begin
                next_state = ST_BURST;
                op = OP_READ;
            end else begin
                next_state = ST_IDLE;
            end
        end else if (ctrl_go) begin
            if (!cap_ce_n && chip_sel) begin
                next_state = ST_BURST;
                op = (wr_mask != `SRAM_LANE_NONE) ? OP_WRITE : OP_READ;
            end else begin
                next_state = ST_IDLE;
            end
        end else if (state == ST_BURST) begin
            // Enables are not looked at here: they count only on an address load
            op = (wr_mask != `SRAM_LANE_NONE) ? OP_WRITE : OP_READ;
        end else begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The order pin is taken as static; a change mid-burst reshuffles the sequence
    assign bus.load = addr_load;
    assign bus.step = !addr_load && state == ST_BURST && !cap_adv_n && !snooze_sync;
    assign bus.linear = !order_sync;
    assign bus.first_low = cap_addr[`SRAM_UPPER_LSB-1:0];

    burst_counter counter_inst (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .bus(bus)
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            base_upper <= '0;
        end else if (addr_load) begin
            base_upper <= cap_addr[`SRAM_ADDR_W-1:`SRAM_UPPER_LSB];
        end
    end

    assign cur_addr = {addr_load ? cap_addr[`SRAM_ADDR_W-1:`SRAM_UPPER_LSB] : base_upper,
                       bus.use_low};

    // Writes queue up and retire into the array on their own
    assign queue_in_valid = op == OP_WRITE;
    assign queue_in_data = {cur_addr, cap_data, wr_mask};
    assign queue_out_ready = !snooze_sync;
    assign drain = queue_out_valid && queue_out_ready;
    assign drain_addr = queue_out_data[`SRAM_QUEUE_ADDR_LSB +: `SRAM_ADDR_W];
    assign drain_data = queue_out_data[`SRAM_QUEUE_DATA_LSB +: `SRAM_DATA_W];
    assign drain_mask = queue_out_data[`SRAM_QUEUE_MASK_LSB +: `SRAM_LANES];
    assign write_queue_ready = queue_in_ready_w;
    assign fwd = drain && drain_addr == cur_addr;

    sync_fifo #(
        .WIDTH(`SRAM_QUEUE_W),
        .DEPTH(`SRAM_QUEUE_DEPTH)
    ) write_queue (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(queue_in_valid),
        .in_ready(queue_in_ready_w),
        .in_data(queue_in_data),
        .out_valid(queue_out_valid),
        .out_ready(queue_out_ready),
        .out_data(queue_out_data)
    );

    // Each lane enable covers eight data bits plus its parity bit; other lanes keep their bits
    genvar lane;
    generate
        for (lane = 0; lane < `SRAM_LANES; lane++) begin : g_lane
            assign merged_word[lane*`SRAM_LANE_W +: `SRAM_LANE_W] = drain_mask[lane]
                ? drain_data[lane*`SRAM_LANE_W +: `SRAM_LANE_W]
                : mem[drain_addr][lane*`SRAM_LANE_W +: `SRAM_LANE_W];
            assign merged_word[`SRAM_PARITY_LSB + lane] = drain_mask[lane]
                ? drain_data[`SRAM_PARITY_LSB + lane]
                : mem[drain_addr][`SRAM_PARITY_LSB + lane];

            // The lane retiring in this very edge is forwarded, the array still holds old data
            assign read_word[lane*`SRAM_LANE_W +: `SRAM_LANE_W] = (fwd && drain_mask[lane])
                ? drain_data[lane*`SRAM_LANE_W +: `SRAM_LANE_W]
                : mem[cur_addr][lane*`SRAM_LANE_W +: `SRAM_LANE_W];
            assign read_word[`SRAM_PARITY_LSB + lane] = (fwd && drain_mask[lane])
                ? drain_data[`SRAM_PARITY_LSB + lane]
                : mem[cur_addr][`SRAM_PARITY_LSB + lane];
        end
    endgenerate

    // One writer for the whole array keeps a single process owning it
    always_ff @(posedge sys_clk) begin
        if (drain) begin
            mem[drain_addr] <= merged_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            data_out <= '0;
        end else if (op == OP_READ) begin
            data_out <= read_word;
        end
    end

    // Any cycle that is not a read, deselect included, floats the bus after this edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= op == OP_READ;
        end
    end

    // Output enable acts without the clock, so it gates the driver directly
    assign data_oe_n = !(out_valid && !output_enable_n && !snooze_sync);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    capture_regs_a: assert property (
        ##1 cap_addr == $past(ext_address) && cap_gw_n == $past(global_write_n))
    else $error("pin not captured on the clock edge");

    proc_read_a: assert property (
        proc_go && chip_sel |=> out_valid)
    else $error("processor strobe did not start a read");

    proc_ignored_a: assert property (
        !cap_proc_n && cap_ce_n && cap_ctrl_n && state != ST_BURST |=> !out_valid)
    else $error("processor strobe used with primary enable high");

    deselect_float_a: assert property (
        out_valid && addr_load && !chip_sel |=> data_oe_n)
    else $error("outputs still driven after deselect");

    oe_gate_a: assert property (
        output_enable_n |-> data_oe_n)
    else $error("data driven with output enable high");

    wait_hold_a: assert property (
        state == ST_BURST && $past(state) == ST_BURST && !addr_load && cap_adv_n
        && !snooze_sync |-> cur_addr == $past(cur_addr))
    else $error("address moved during a wait state");

    upper_hold_a: assert property (
        addr_load ##1 (!addr_load && state == ST_BURST)[*3]
        |-> cur_addr[`SRAM_ADDR_W-1:`SRAM_UPPER_LSB]
            == $past(cap_addr[`SRAM_ADDR_W-1:`SRAM_UPPER_LSB], 3))
    else $error("upper address changed inside a burst");

    global_write_a: assert property (
        queue_in_valid && !cap_gw_n |-> queue_in_data[`SRAM_LANES-1:0] == `SRAM_LANE_ALL)
    else $error("global write did not select every lane");

    gate_blocks_a: assert property (
        state == ST_BURST && !addr_load && cap_gw_n && cap_bwe_n |=> !$past(queue_in_valid))
    else $error("lane write without the byte write gate");

    read_data_a: assert property (
        op == OP_READ && !drain ##1 !snooze_sync && !output_enable_n
        |-> !data_oe_n && data_out == mem[$past(cur_addr)])
    else $error("read data not presented one edge later");

    ctrl_power_down_a: assert property (
        ctrl_go && cap_ce_n |=> !out_valid && !$past(queue_in_valid))
    else $error("controller strobe used with primary enable high");

    snooze_quiet_a: assert property (
        snooze_sync |=> !out_valid)
    else $error("access taken during snooze");

endmodule // sram_burst_port

`default_nettype wire

// [test/sram_bus_master.sv]
`include "sram_consts.svh"
`timescale 1ns/1ns
`default_nettype none

// Bus master side of the memory port; every pin changes on the falling edge only
module sram_bus_master (
    input wire logic sys_clk,
    output logic [`SRAM_ADDR_W-1:0] ext_address,
    output logic chip_enable_n,
    output logic second_chip_enable_n,
    output logic third_chip_enable,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_advance_n,
    output logic byte_write_gate_n,
    output logic global_write_n,
    output logic [`SRAM_LANES-1:0] lane_write_enable_n,
    output logic [`SRAM_DATA_W-1:0] data_in
);
    logic last_proc;

    initial begin
        {chip_enable_n, second_chip_enable_n, third_chip_enable} = 3'h1;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
        {global_write_n, byte_write_gate_n, lane_write_enable_n} = 6'h3F;
        ext_address = '0;
        data_in = '0;
        last_proc = 1'b0;
    end

    // strb = {proc, ctrl, advance}, en = {primary_n, second_n, third}, wr = {global_n, gate_n, lanes_n}
    task automatic drive(input logic [2:0] strb, input logic [2:0] en, input logic [5:0] wr,
            input logic [15:0] addr, input logic [35:0] d);
        @(negedge sys_clk);
        proc_addr_strobe_n = strb[2];
        ctrl_addr_strobe_n = strb[1];
        // Held high after a processor strobe so a following write keeps the loaded address
        burst_advance_n = last_proc | strb[0];
        last_proc = ~strb[2];
        {chip_enable_n, second_chip_enable_n, third_chip_enable} = en;
        {global_write_n, byte_write_gate_n, lane_write_enable_n} = wr;
        ext_address = addr;
        // Outside writes the data wires toggle, so a stale word can never pass for a match
        data_in = (wr[5] && (wr[4] || &wr[3:0])) ? ~data_in : d;
    endtask
endmodule // sram_bus_master

`default_nettype wire

// [test/test_pipelined_burst_sram_port.sv]
`include "sram_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module test_pipelined_burst_sram_port;
    import sram_pkg::*;

    logic sys_clk;
    logic sys_rst;
    logic output_enable_n;
    logic snooze_request;
    logic burst_order;
    wire logic [`SRAM_ADDR_W-1:0] ext_address;
    wire logic chip_enable_n, second_chip_enable_n, third_chip_enable;
    wire logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
    wire logic byte_write_gate_n, global_write_n;
    wire logic [`SRAM_LANES-1:0] lane_write_enable_n;
    wire logic [`SRAM_DATA_W-1:0] data_in;
    logic [`SRAM_DATA_W-1:0] data_out;
    logic data_oe_n;
    logic write_queue_ready;
    logic [36:0] obs[$];
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    sram_bus_master bus (.sys_clk, .ext_address, .chip_enable_n, .second_chip_enable_n,
        .third_chip_enable, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
        .byte_write_gate_n, .global_write_n, .lane_write_enable_n, .data_in);

    sram_burst_port uut (.sys_clk, .sys_rst, .ext_address, .chip_enable_n,
        .second_chip_enable_n, .third_chip_enable, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
        .burst_advance_n, .byte_write_gate_n, .global_write_n, .lane_write_enable_n, .data_in,
        .output_enable_n, .snooze_request, .burst_order, .data_out, .data_oe_n,
        .write_queue_ready);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Mismatches: %0d, comparisons: %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Output seen at index n belongs to the pins driven at index n-2
    task automatic step(input logic [2:0] strb, input logic [2:0] en, input logic [5:0] wr,
            input logic [15:0] addr, input logic [35:0] d);
        bus.drive(strb, en, wr, addr, d);
        obs.push_back({data_oe_n, data_out});
    endtask

    // Enables given as don't-care values on purpose: they must not matter outside loads
    task automatic idle();
        step(3'h7, 3'h6, 6'h3F, 16'hFFFF, 36'h0);
    endtask

    task automatic cont();
        step(3'h6, 3'h6, 6'h3F, 16'hFFFF, 36'h0);
    endtask

    task automatic rd(input logic [15:0] addr);
        step(3'h3, 3'h1, 6'h3F, addr, 36'h0);
    endtask

    task automatic wr(input logic [15:0] addr, input logic [5:0] w, input logic [35:0] d);
        step(3'h5, 3'h1, w, addr, d);
    endtask

    task automatic t_reset();
        check({data_oe_n, data_out}, {1'b1, 36'h0});
        check({36'h0, write_queue_ready}, 37'h1);
    endtask

    task automatic t_writes();
        int b;
        b = obs.size();
        wr(16'h0010, 6'h1F, 36'h912345678);
        idle();
        idle();
        rd(16'h0010);
        idle();
        idle();
        check(obs[b+5], {1'b0, 36'h912345678});
        b = obs.size();
        wr(16'h0010, 6'h2A, 36'h6AABBCCDD);
        wr(16'h0010, 6'h30, 36'hFFFFFFFFF);
        wr(16'h0010, 6'h2F, 36'hFFFFFFFFF);
        rd(16'h0010);
        idle();
        idle();
        check(obs[b+5], {1'b0, 36'hC12BB56DD});
    endtask

    task automatic t_burst(input logic mode);
        int b;
        logic [9:0] seq;
        logic [1:0] lo;
        seq = 10'b11_10_01_01_00;
        step(3'h5, 3'h3, 6'h3F, 16'h0, 36'h0);
        burst_order = mode;
        repeat (3) idle();
        for (int k = 0; k < 4; k++) begin
            wr(16'(16'h0120 + k), 6'h1F, 36'(36'h5000A0120 + k));
        end
        check({36'h0, write_queue_ready}, 37'h1);
        b = obs.size();
        wr(16'h0121, 6'h3F, 36'h0);
        cont();
        idle();
        cont();
        cont();
        idle();
        idle();
        for (int k = 0; k < 5; k++) begin
            lo = mode ? (2'h1 ^ seq[2*k+:2]) : (2'h1 + seq[2*k+:2]);
            check(obs[b+k+2], {1'b0, 36'(36'h5000A0120 + lo)});
        end
    endtask

    task automatic t_deselect();
        int b;
        logic [8:0] ens;
        ens = 9'b011_000_101;
        for (int k = 0; k < 3; k++) begin
            b = obs.size();
            rd(16'h0010);
            step(3'h5, ens[3*k+:3], 6'h3F, 16'h0010, 36'h0);
            idle();
            idle();
            check(obs[b+2], {1'b0, 36'hC12BB56DD});
            check({36'h0, obs[b+3][36]}, 37'h1);
        end
        b = obs.size();
        step(3'h3, 3'h5, 6'h3F, 16'h0010, 36'h0);
        idle();
        idle();
        check({36'h0, obs[b+2][36]}, 37'h1);
    endtask

    task automatic t_write_after_proc();
        int b;
        b = obs.size();
        rd(16'h0123);
        step(3'h6, 3'h6, 6'h1F, 16'hFFFF, 36'h3CAFE0042);
        idle();
        rd(16'h0123);
        idle();
        idle();
        check(obs[b+2], {1'b0, 36'h5000A0123});
        check(obs[b+5], {1'b0, 36'h3CAFE0042});
    endtask

    // Snooze must swallow a read that would otherwise drive the wires
    task automatic t_snooze();
        int b;
        snooze_request = 1'b1;
        repeat (3) idle();
        b = obs.size();
        rd(16'h0010);
        idle();
        idle();
        check({36'h0, obs[b+2][36]}, 37'h1);
        snooze_request = 1'b0;
        repeat (3) idle();
    endtask

    task automatic t_output_enable();
        int b;
        b = obs.size();
        output_enable_n = 1'b1;
        rd(16'h0010);
        idle();
        idle();
        check({36'h0, obs[b+2][36]}, 37'h1);
        output_enable_n = 1'b0;
        #1;
        check({data_oe_n, data_out}, {1'b0, 36'hC12BB56DD});
    endtask

    initial begin
        sys_rst = 1'b1;
        output_enable_n = 1'b0;
        snooze_request = 1'b0;
        burst_order = 1'b1;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_writes();
        t_burst(1'b0);
        t_burst(1'b1);
        t_deselect();
        t_snooze();
        t_write_after_proc();
        t_output_enable();
        final_report();
    end
endmodule // test_pipelined_burst_sram_port

`default_nettype wire
